// ---- design/iflag_consts.vh ----
// Register offsets, field positions, reset values and masks of the interrupt flag block.
`ifndef IFLAG_CONSTS_VH
`define IFLAG_CONSTS_VH
`define IFLAG_OFF_GROUP1      4'h0
`define IFLAG_OFF_GROUP2      4'h4
`define IFLAG_OFF_MASK1       4'h8
`define IFLAG_OFF_MASK2       4'hc
`define IFLAG_BIT_SLAVE       0
`define IFLAG_BIT_MASTER      1
`define IFLAG_BIT_COMP        2
`define IFLAG_BIT_CHANGE      3
`define IFLAG_BIT_EXT1        4
`define IFLAG_BIT_EXT2        13
`define IFLAG_BIT_TIMER5      12
`define IFLAG_BIT_TIMER4      11
`define IFLAG_BIT_CAPT3       5
`define IFLAG_IMPL_GROUP1     16'h381f
`define IFLAG_IMPL_GROUP2     16'h0020
`define IFLAG_RST_FLAGS       16'h0000
`define IFLAG_RST_MASK        16'h0000
`define IFLAG_RESP_OKAY       2'b00
`define IFLAG_RESP_SLVERR     2'b10
`endif

// ---- design/iflag_sync.v ----
// Two-stage synchroniser for a vector of request inputs.
`timescale 1ns/1ps
module iflag_sync
#(
  parameter WIDTH = 8
)
(
  input  wire             aclk,
  input  wire             aresetn,
  input  wire [WIDTH-1:0] async_in,
  output reg  [WIDTH-1:0] sync_out
);
  reg [WIDTH-1:0] meta_q;

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      meta_q   <= {WIDTH{1'b0}};
      sync_out <= {WIDTH{1'b0}};
    end
    else
    begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule

// ---- design/iflag_regs.v ----
// Interrupt flag status registers with an AXI4-Lite slave and a masked interrupt output.
// How it works
// - Flag sets on a rising request edge and reads one until software clears it.
// - Every flag clears at reset.
// - Software reads and writes flags, writing zero clears.
// - Group1 bit 4 is external interrupt 1.
// - Group1 bit 3 is change notification.
// - Group1 bit 2 is comparator flag.
// - Group2 bit 5 is capture channel 3.
// - Other group2 bits read zero, ignore writes.
//
// The implementer's own choices: the address map and register access over AXI4-Lite.
`timescale 1ns/1ps
`include "iflag_consts.vh"
module iflag_regs
#(
  parameter HAS_TIMER4 = 1
)
(
  input  wire        aclk,
  input  wire        aresetn,
  input  wire        ext_irq1_req,
  input  wire        change_notify_req,
  input  wire        comparator_req,
  input  wire        i2c_master_event_req,
  input  wire        i2c_slave_event_req,
  input  wire        timer4_req,
  input  wire        timer5_req,
  input  wire        ext_irq2_req,
  input  wire        capture3_req,
  input  wire [3:0]  s_axi_awaddr,
  input  wire [2:0]  s_axi_awprot,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [3:0]  s_axi_araddr,
  input  wire [2:0]  s_axi_arprot,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  output reg         irq
);
  // ***********************************************************
  // Request synchronisation and edge detection.
  // ***********************************************************
  wire [8:0] req_sync;
  reg  [8:0] req_prev_q;
  reg  [15:0] raise1;
  reg  [15:0] raise2;
  wire [8:0] req_rise;

  iflag_sync #(.WIDTH(9)) u_sync
  (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .async_in ({capture3_req, ext_irq2_req, timer5_req, timer4_req, i2c_slave_event_req,
                i2c_master_event_req, comparator_req, change_notify_req, ext_irq1_req}),
    .sync_out (req_sync)
  );

  assign req_rise = req_sync & ~req_prev_q;

  always @(posedge aclk)
  begin
    if (!aresetn)
      req_prev_q <= 9'h000;
    else
      req_prev_q <= req_sync;
  end

  always @*
  begin
    raise1 = 16'h0000;
    raise2 = 16'h0000;
    raise1[`IFLAG_BIT_EXT1]   = req_rise[0];
    raise1[`IFLAG_BIT_CHANGE] = req_rise[1];
    raise1[`IFLAG_BIT_COMP]   = req_rise[2];
    raise1[`IFLAG_BIT_MASTER] = req_rise[3];
    raise1[`IFLAG_BIT_SLAVE]  = req_rise[4];
    raise1[`IFLAG_BIT_TIMER4] = req_rise[5] & (HAS_TIMER4 != 0);
    raise1[`IFLAG_BIT_TIMER5] = req_rise[6];
    raise1[`IFLAG_BIT_EXT2]   = req_rise[7];
    raise2[`IFLAG_BIT_CAPT3]  = req_rise[8];
  end

  // ***********************************************************
  // Address decode helpers.
  // ***********************************************************
  function [1:0] reg_sel;
    input [3:0] addr;
    begin
      reg_sel = addr[3:2];
    end
  endfunction

  wire [15:0] impl1 = HAS_TIMER4 != 0 ? `IFLAG_IMPL_GROUP1 : (`IFLAG_IMPL_GROUP1 & 16'hf7ff);
  wire [15:0] impl2 = `IFLAG_IMPL_GROUP2;

  // ***********************************************************
  // Write channel.
  // ***********************************************************
  reg        aw_have_q;
  reg        w_have_q;
  reg [3:0]  aw_addr_q;
  reg [31:0] w_data_q;
  reg [3:0]  w_strb_q;
  reg [15:0] flags1_q;
  reg [15:0] flags2_q;
  reg [15:0] mask1_q;
  reg [15:0] mask2_q;
  wire       wr_fire = aw_have_q & w_have_q & ~s_axi_bvalid;
  wire [15:0] wbe = {{8{w_strb_q[1]}}, {8{w_strb_q[0]}}};
  wire [15:0] wval = w_data_q[15:0];

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_have_q     <= 1'b0;
      w_have_q      <= 1'b0;
      aw_addr_q     <= 4'h0;
      w_data_q      <= 32'h00000000;
      w_strb_q      <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `IFLAG_RESP_OKAY;
    end
    else
    begin
      s_axi_awready <= ~aw_have_q & ~s_axi_awready & s_axi_awvalid;
      s_axi_wready  <= ~w_have_q & ~s_axi_wready & s_axi_wvalid;
      if (s_axi_awvalid & s_axi_awready)
      begin
        aw_have_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid & s_axi_wready)
      begin
        w_have_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (wr_fire)
      begin
        aw_have_q    <= 1'b0;
        w_have_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= `IFLAG_RESP_OKAY;
      end
      else if (s_axi_bvalid & s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // ***********************************************************
  // Flag and mask registers; a new request wins over a clear.
  // ***********************************************************
  wire wr1 = wr_fire & (reg_sel(aw_addr_q) == reg_sel(`IFLAG_OFF_GROUP1));
  wire wr2 = wr_fire & (reg_sel(aw_addr_q) == reg_sel(`IFLAG_OFF_GROUP2));
  wire wm1 = wr_fire & (reg_sel(aw_addr_q) == reg_sel(`IFLAG_OFF_MASK1));
  wire wm2 = wr_fire & (reg_sel(aw_addr_q) == reg_sel(`IFLAG_OFF_MASK2));

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      flags1_q <= `IFLAG_RST_FLAGS;
      flags2_q <= `IFLAG_RST_FLAGS;
      mask1_q  <= `IFLAG_RST_MASK;
      mask2_q  <= `IFLAG_RST_MASK;
    end
    else
    begin
      flags1_q <= ((wr1 ? ((flags1_q & ~wbe) | (wval & wbe)) : flags1_q) | raise1) & impl1;
      flags2_q <= ((wr2 ? ((flags2_q & ~wbe) | (wval & wbe)) : flags2_q) | raise2) & impl2;
      if (wm1)
        mask1_q <= ((mask1_q & ~wbe) | (wval & wbe)) & impl1;
      if (wm2)
        mask2_q <= ((mask2_q & ~wbe) | (wval & wbe)) & impl2;
    end
  end

  // ***********************************************************
  // Read channel.
  // ***********************************************************
  reg [15:0] rd_mux;

  always @*
  begin
    case (reg_sel(s_axi_araddr))
      2'd0:    rd_mux = flags1_q;
      2'd1:    rd_mux = flags2_q & impl2;
      2'd2:    rd_mux = mask1_q;
      default: rd_mux = mask2_q;
    endcase
  end

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `IFLAG_RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
      if (s_axi_arvalid & s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= {16'h0000, rd_mux};
        s_axi_rresp  <= `IFLAG_RESP_OKAY;
      end
      else if (s_axi_rvalid & s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  // ***********************************************************
  // Interrupt output.
  // ***********************************************************
  always @(posedge aclk)
  begin
    if (!aresetn)
      irq <= 1'b0;
    else
      irq <= |(flags1_q & mask1_q) | |(flags2_q & mask2_q);
  end
endmodule

// ---- sim/iflag_regs_checker.sv ----
// Checker of bus and interrupt behaviour at the flag block ports.
`timescale 1ns/1ps
module iflag_chk
(
  input wire        aclk,
  input wire        aresetn,
  input wire        s_axi_awready,
  input wire        s_axi_wready,
  input wire [1:0]  s_axi_bresp,
  input wire        s_axi_bvalid,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0]  s_axi_rresp,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  input wire        irq
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  rst_quiet_a: assert property (disable iff (1'b0) !aresetn |=> !irq && !s_axi_bvalid && !s_axi_rvalid)
    else $error("outputs not quiet after reset");
  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  upper_zero_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
    else $error("upper read bits not zero");
  rresp_ok_a: assert property (s_axi_rvalid |-> s_axi_rresp == 2'b00)
    else $error("read response not okay");
  bresp_ok_a: assert property (s_axi_bvalid |-> s_axi_bresp == 2'b00)
    else $error("write response not okay");
  aw_pulse_a: assert property (s_axi_awready |=> !s_axi_awready)
    else $error("awready held");
  w_pulse_a: assert property (s_axi_wready |=> !s_axi_wready)
    else $error("wready held");
  ar_pulse_a: assert property (s_axi_arready |=> !s_axi_arready)
    else $error("arready held");
  r_drop_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("rvalid kept after handshake");
  cover property (s_axi_bvalid);
  cover property (s_axi_rvalid && s_axi_rdata != 32'h0);
  cover property ($rose(irq));
endmodule

// ---- sim/iflag_regs_tb.sv ----
// Self-checking bench for the interrupt flag registers.
`timescale 1ns/1ps
`include "iflag_consts.vh"
module iflag_regs_tb;
  logic        aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_arvalid = 0;
  logic [8:0]  req = 0;
  logic [3:0]  s_axi_awaddr = 0, s_axi_araddr = 0, s_axi_wstrb = 4'hf;
  logic [31:0] s_axi_wdata = 0, d, r;
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
  wire [1:0]   s_axi_bresp, s_axi_rresp;
  wire [31:0]  s_axi_rdata;
  int          fail_count = 0, comparisons = 0;
  int          pos [9] = '{4, 3, 2, 1, 0, 11, 12, 13, 5};
  always #5 aclk = ~aclk;
  iflag_regs i_iflag_regs (.ext_irq1_req(req[0]), .change_notify_req(req[1]), .comparator_req(req[2]),
    .i2c_master_event_req(req[3]), .i2c_slave_event_req(req[4]), .timer4_req(req[5]), .timer5_req(req[6]),
    .ext_irq2_req(req[7]), .capture3_req(req[8]), .s_axi_awprot(3'h0), .s_axi_arprot(3'h0),
    .s_axi_bready(1'b1), .s_axi_rready(1'b1), .*);
  function automatic logic [31:0] expect_rd(input logic [3:0] a, input logic [31:0] v);
    expect_rd = v & ((a == `IFLAG_OFF_GROUP2) ? `IFLAG_IMPL_GROUP2 : `IFLAG_IMPL_GROUP1);
  endfunction
  task chk(input [31:0] s, input [31:0] e);
    comparisons++;
    if (s !== e) begin fail_count++; $display("BAD t=%0t seen=%h exp=%h", $time, s, e); end
  endtask
  task results;
    $display("comparisons=%0d fail_count=%0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task wr(input [3:0] a, input [31:0] v);
    int n;
    n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do
    begin
      @(posedge aclk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    while (!s_axi_bvalid && n < 50);
    if (n >= 50) fail_count++;
  endtask
  task rd(input [3:0] a, output [31:0] v);
    int n;
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do
    begin
      @(posedge aclk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    while (!s_axi_rvalid && n < 50);
    v = s_axi_rdata;
    if (n >= 50) fail_count++;
  endtask
  task pulse(input int i);
    req[i] <= 1'b1;
    repeat (6) @(posedge aclk);
    req[i] <= 1'b0;
  endtask
  initial
  begin
    #100us;
    fail_count++;
    results;
  end
  initial
  begin
    void'($urandom(32'h9c8c));
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    for (int a = 0; a < 16; a += 4)
    begin
      rd(4'(a), d);
      chk(d, 32'h0);
    end
    $display("test reset done");
    for (int i = 0; i < 9; i++)
    begin
      pulse(i);
      rd(i == 8 ? 4'h4 : 4'h0, d);
      chk(d, 32'h1 << pos[i]);
      wr(i == 8 ? 4'h4 : 4'h0, 32'h0);
      rd(i == 8 ? 4'h4 : 4'h0, d);
      chk(d, 32'h0);
    end
    $display("test sources done");
    for (int k = 0; k < 20; k++)
    begin
      r = (k == 0) ? 32'hffffffff : $urandom;
      wr(4'h0, r);
      rd(4'h0, d);
      chk(d, expect_rd(4'h0, r));
      wr(4'h4, r);
      rd(4'h4, d);
      chk(d, expect_rd(4'h4, r));
    end
    wr(4'h0, 32'h0);
    s_axi_wstrb <= 4'h1;
    wr(4'h0, 32'hffffffff);
    s_axi_wstrb <= 4'hf;
    rd(4'h0, d);
    chk(d, expect_rd(4'h0, 32'h000000ff));
    wr(4'h0, 32'h0);
    wr(4'h4, 32'h0);
    $display("test access done");
    wr(4'h8, 32'h10);
    pulse(0);
    chk(irq, 1);
    wr(4'h8, 32'h0);
    repeat (2) @(posedge aclk);
    chk(irq, 0);
    wr(4'h8, 32'h10);
    repeat (2) @(posedge aclk);
    chk(irq, 1);
    wr(4'h0, 32'h0);
    repeat (2) @(posedge aclk);
    chk(irq, 0);
    $display("test interrupt done");
    results;
  end
endmodule
bind iflag_regs iflag_chk i_iflag_chk (.*);
